/* File: p4mux_port.sv */
`timescale 1ns/10ps
module p4mux_port
  import p4mux_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // operating mode and standby
  input wire logic mode1,
  input wire logic expanded_bus_enable,
  input wire logic hw_standby,
  // alternate function sources
  input wire logic sys_clock_out,
  input wire p4mux_strobe_t strobes,
  input wire logic i2c_data_out_low,
  // pins: input, output, output enable (low = driving)
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe_n,
  // alternate function inputs to peripherals
  output p4mux_alt_in_t alt_in
);

  logic [7:0] port4_output_latch_reg;
  logic [7:0] port4_direction_reg;
  logic [7:0] ctrl_reg;
  logic [31:0] prdata_reg;
  logic pslverr_reg;
  logic pready_reg;
  logic [7:0] pin_out_reg;
  logic [7:0] oe_n_reg;
  logic [7:0] pin_out_next;
  logic [7:0] oe_n_next;
  p4mux_alt_in_t alt_reg;
  p4mux_alt_in_t alt_next;
  logic [7:0] read_view;
  logic wr_en;
  logic rd_en;
  logic mapped;
  logic mode1_q;

  // writes land on every access phase edge, two per transfer; lane 0 carries the byte
  assign wr_en = psel && penable && pwrite && pstrb[0];
  assign rd_en = psel && penable && !pwrite;
  assign mapped = (paddr == P4MUX_LATCH_OFS) || (paddr == P4MUX_DIR_OFS) ||
                  (paddr == P4MUX_CTRL_OFS) || (paddr == P4MUX_PIN_OFS);

  // mode strap is caught by a clocked process, never inside reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode1_q <= 1'b0;
    end else begin
      mode1_q <= mode1;
    end
  end

  // data latch: hw standby clears like reset, sw standby needs no special case
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port4_output_latch_reg <= P4MUX_LATCH_RST;
    end else if (hw_standby) begin
      port4_output_latch_reg <= P4MUX_LATCH_RST;
    end else if (wr_en && paddr == P4MUX_LATCH_OFS) begin
      port4_output_latch_reg <= pwdata[7:0];
    end
  end

  // direction: async reset takes mode-2/3 value; mode-1 value is loaded after release
  // and in hw standby, since a strap cannot feed an async reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port4_direction_reg <= P4MUX_DIR_RST_MODE23;
    end else if (hw_standby) begin
      port4_direction_reg <= mode1 ? P4MUX_DIR_RST_MODE1 : P4MUX_DIR_RST_MODE23;
    end else if (wr_en && paddr == P4MUX_DIR_OFS) begin
      port4_direction_reg <= pwdata[7:0];
    end else if (mode1 && !mode1_q) begin
      port4_direction_reg <= P4MUX_DIR_RST_MODE1;
    end
  end

  // alternate-function enables held in a local control register written over apb
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= P4MUX_CTRL_RST;
    end else if (hw_standby) begin
      ctrl_reg <= P4MUX_CTRL_RST;
    end else if (wr_en && paddr == P4MUX_CTRL_OFS) begin
      ctrl_reg <= pwdata[7:0];
    end
  end

  // read view: latch where driven, pin where input; bit6 always follows its pin
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      read_view[i] = port4_direction_reg[i] ? port4_output_latch_reg[i] : pin_in[i];
    end
    read_view[P4MUX_CLK_BIT] = pin_in[P4MUX_CLK_BIT];
  end

  // apb answer one cycle after the access phase starts; direction reads as zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
      pready_reg <= 1'b0;
    end else begin
      pready_reg <= psel && penable && !pready_reg;
      pslverr_reg <= psel && penable && !pready_reg && !mapped;
      prdata_reg <= 32'h0000_0000;
      if (rd_en && !pready_reg) begin
        case (paddr)
          P4MUX_LATCH_OFS: prdata_reg <= {24'h000000, read_view};
          P4MUX_CTRL_OFS: prdata_reg <= {24'h000000, ctrl_reg};
          P4MUX_PIN_OFS: prdata_reg <= {24'h000000, pin_in};
          default: prdata_reg <= 32'h0000_0000;
        endcase
      end
    end
  end

  // pin function selection, per bit
  always_comb begin
    pin_out_next = port4_output_latch_reg;
    oe_n_next = ~port4_direction_reg;
    // bit7: wait input, i2c open drain, or port
    if (expanded_bus_enable && ctrl_reg[P4MUX_CTRL_WMS]) begin
      oe_n_next[7] = 1'b1;
    end else if (ctrl_reg[P4MUX_CTRL_I2C]) begin
      pin_out_next[7] = 1'b0;
      oe_n_next[7] = ~i2c_data_out_low;
    end
    // bit6: clock out when dir set, otherwise input (port or subclock)
    pin_out_next[6] = sys_clock_out;
    oe_n_next[6] = ~port4_direction_reg[6];
    // bits 5..3: bus strobes in expanded modes, direction ignored
    if (expanded_bus_enable) begin
      pin_out_next[5] = ctrl_reg[P4MUX_CTRL_IO_STROBE_ENABLE] ? strobes.io_strobe_n :
                        strobes.address_strobe_n;
      pin_out_next[4] = strobes.write_strobe_n;
      pin_out_next[3] = strobes.read_strobe_n;
      oe_n_next[5:3] = 3'b000;
    end
  end

  // registered pins; a clock out through a flop is delayed one cycle, noted as a limit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out_reg <= 8'h00;
      oe_n_reg <= 8'hff;
    end else if (hw_standby) begin
      pin_out_reg <= 8'h00;
      oe_n_reg <= 8'hff;
    end else begin
      pin_out_reg <= pin_out_next;
      oe_n_reg <= oe_n_next;
    end
  end

  // alternate inputs; inactive level is one for the active-low lines
  always_comb begin
    alt_next.wait_request_n = (expanded_bus_enable && ctrl_reg[P4MUX_CTRL_WMS]) ?
                              pin_in[7] : 1'b1;
    alt_next.i2c_data_in = ctrl_reg[P4MUX_CTRL_I2C] ? pin_in[7] : 1'b1;
    alt_next.subclock_input = (!port4_direction_reg[6] && ctrl_reg[P4MUX_CTRL_SUBCLOCK_INPUT]) ?
                              pin_in[6] : 1'b0;
    alt_next.ext_int_a_n = ctrl_reg[P4MUX_CTRL_IRQA] ? pin_in[2] : 1'b1;
    alt_next.ext_int_b_n = ctrl_reg[P4MUX_CTRL_IRQB] ? pin_in[1] : 1'b1;
    alt_next.ext_int_c_n = ctrl_reg[P4MUX_CTRL_IRQC] ? pin_in[0] : 1'b1;
    alt_next.adc_ext_trigger_n = ctrl_reg[P4MUX_CTRL_TRG] ? pin_in[0] : 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alt_reg <= '{wait_request_n: 1'b1, i2c_data_in: 1'b1, subclock_input: 1'b0,
                   ext_int_a_n: 1'b1, ext_int_b_n: 1'b1, ext_int_c_n: 1'b1,
                   adc_ext_trigger_n: 1'b1};
    end else begin
      alt_reg <= alt_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign pin_out = pin_out_reg;
  assign pin_oe_n = oe_n_reg;
  assign alt_in = alt_reg;

endmodule

/* File: p4mux_pkg.sv */
package p4mux_pkg;
  // register byte addresses on the apb slave
  localparam logic [11:0] P4MUX_LATCH_OFS = 12'h000;
  localparam logic [11:0] P4MUX_DIR_OFS = 12'h004;
  localparam logic [11:0] P4MUX_CTRL_OFS = 12'h008;
  localparam logic [11:0] P4MUX_PIN_OFS = 12'h00c;
  // reset values
  localparam logic [7:0] P4MUX_LATCH_RST = 8'h00;
  localparam logic [7:0] P4MUX_DIR_RST_MODE1 = 8'h40;
  localparam logic [7:0] P4MUX_DIR_RST_MODE23 = 8'h00;
  localparam logic [7:0] P4MUX_CTRL_RST = 8'h00;
  // field positions
  localparam int P4MUX_CLK_BIT = 6;
  localparam int P4MUX_CTRL_WMS = 0;
  localparam int P4MUX_CTRL_I2C = 1;
  localparam int P4MUX_CTRL_SUBCLOCK_INPUT = 2;
  localparam int P4MUX_CTRL_IO_STROBE_ENABLE = 3;
  localparam int P4MUX_CTRL_IRQA = 4;
  localparam int P4MUX_CTRL_IRQB = 5;
  localparam int P4MUX_CTRL_IRQC = 6;
  localparam int P4MUX_CTRL_TRG = 7;

  // bus strobes arriving from the bus controller, all active low
  typedef struct packed {
    logic address_strobe_n;
    logic io_strobe_n;
    logic write_strobe_n;
    logic read_strobe_n;
  } p4mux_strobe_t;

  // alternate-function inputs taken from the pins
  typedef struct packed {
    logic wait_request_n;
    logic i2c_data_in;
    logic subclock_input;
    logic ext_int_a_n;
    logic ext_int_b_n;
    logic ext_int_c_n;
    logic adc_ext_trigger_n;
  } p4mux_alt_in_t;
endpackage

/* File: p4mux_port_monitor.sv */
`timescale 1ns/10ps
module p4mux_port_monitor
  import p4mux_pkg::*;
(
  // apb side
  input logic pclk, presetn, psel, penable, pwrite, pready,
  input logic [11:0] paddr,
  input logic [31:0] prdata,
  // mode, sources and pins
  input logic expanded_bus_enable, hw_standby, sys_clock_out,
  input p4mux_strobe_t strobes,
  input p4mux_alt_in_t alt_in,
  input logic [7:0] pin_in, pin_out, pin_oe_n
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // apb answer one cycle after the first access edge, one cycle wide
  property p_ans; psel && penable && !$past(penable) |=> pready; endproperty
  a_ans: assert property (p_ans) else $error("no answer after access");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
  property p_dir_rd; pready && !pwrite && paddr == P4MUX_DIR_OFS |-> prdata == 32'h0; endproperty
  a_dir_rd: assert property (p_dir_rd) else $error("direction read not zero");
  property p_bit6_rd;
    pready && !pwrite && paddr == P4MUX_LATCH_OFS |-> prdata[6] == $past(pin_in[6]); endproperty
  a_bit6_rd: assert property (p_bit6_rd) else $error("bit6 not pin level");
  // strobes follow the bus controller one cycle late in expanded modes
  property p_bit4;
    expanded_bus_enable && !hw_standby |=> !pin_oe_n[4] && pin_out[4] == $past(strobes.write_strobe_n);
  endproperty
  a_bit4: assert property (p_bit4) else $error("write strobe pin wrong");
  property p_bit3;
    expanded_bus_enable && !hw_standby |=> !pin_oe_n[3] && pin_out[3] == $past(strobes.read_strobe_n);
  endproperty
  a_bit3: assert property (p_bit3) else $error("read strobe pin wrong");
  property p_bit5; expanded_bus_enable && !hw_standby |=> !pin_oe_n[5] &&
    (pin_out[5] == $past(strobes.address_strobe_n) || pin_out[5] == $past(strobes.io_strobe_n));
  endproperty
  a_bit5: assert property (p_bit5) else $error("address strobe pin wrong");
  property p_clk; !pin_oe_n[6] |-> pin_out[6] == $past(sys_clock_out); endproperty
  a_clk: assert property (p_clk) else $error("clock pin wrong");
  property p_wait; !expanded_bus_enable |=> alt_in.wait_request_n; endproperty
  a_wait: assert property (p_wait) else $error("wait input live in single chip");
  property p_stby; hw_standby |=> pin_oe_n == 8'hff && pin_out == 8'h00; endproperty
  a_stby: assert property (p_stby) else $error("pins driven in standby");
endmodule

/* File: p4mux_board.sv */
`timescale 1ns/10ps
// board: a driven pin shows the port level, a released one the outside level
module p4mux_board (
  // port side and outside level
  input logic [7:0] pin_out, pin_oe_n, ext_level,
  // level seen back at the port
  output logic [7:0] pin_in
);
  assign pin_in = (pin_out & ~pin_oe_n) | (ext_level & pin_oe_n);
endmodule

/* File: p4mux_port_tb.sv */
`timescale 1ns/10ps
module p4mux_port_tb;
  import p4mux_pkg::*;
  logic pclk = '0, presetn = '0, psel = '0, penable = '0, pwrite = '0, err;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [3:0] pstrb = 4'hf;
  logic pready, pslverr, mode1 = 1'b1, expanded_bus_enable = '0, hw_standby = '0;
  logic sys_clock_out = '0, i2c_data_out_low = '0;
  p4mux_strobe_t strobes = '0;
  p4mux_alt_in_t alt_in;
  logic [7:0] pin_in, pin_out, pin_oe_n, ext = '0, d, r, c, p;
  int n_fail = 0, n_compared = 0;
  p4mux_port p4mux_port_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .mode1, .expanded_bus_enable, .hw_standby,
    .sys_clock_out, .strobes, .i2c_data_out_low, .pin_in, .pin_out, .pin_oe_n, .alt_in);
  p4mux_board p4mux_board_inst (.pin_out, .pin_oe_n, .ext_level(ext), .pin_in);
  initial forever #5 pclk = ~pclk;
  task automatic chk(input logic [31:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // one apb transfer; the request holds until ready is seen at an edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] w);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, w};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // latch where driven, outside level where released; bit6 always the pin
  function automatic logic [31:0] rd_exp(logic [7:0] d, r);
    logic [7:0] q;
    q = (d & r) | (ext & ~r);
    q[6] = r[6] ? sys_clock_out : ext[6];
    return {24'h0, q};
  endfunction
  initial begin
    #100000;
    n_fail++;
    final_report;
  end
  initial begin
    d = $urandom(78);
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    chk(pin_oe_n, 8'hbf);
    apb(1'b0, P4MUX_LATCH_OFS, 8'h00);
    chk(rd, 32'h0);
    apb(1'b0, P4MUX_DIR_OFS, 8'h00);
    apb(1'b0, 12'h010, 8'h00);
    chk(err, 1'b1);
    $display("reset state done");
    repeat (12) begin
      d = $urandom;
      r = $urandom;
      ext <= $urandom;
      sys_clock_out <= $urandom;
      apb(1'b1, P4MUX_LATCH_OFS, d);
      apb(1'b1, P4MUX_DIR_OFS, r);
      apb(1'b0, P4MUX_LATCH_OFS, 8'h00);
      chk(pin_oe_n, {24'h0, ~r});
      chk(rd, rd_exp(d, r));
    end
    $display("single chip port done");
    apb(1'b1, P4MUX_DIR_OFS, 8'h00);
    repeat (10) begin
      c = $urandom;
      ext <= $urandom;
      i2c_data_out_low <= $urandom;
      apb(1'b1, P4MUX_CTRL_OFS, c);
      apb(1'b0, P4MUX_CTRL_OFS, 8'h00);
      chk(rd, {24'h0, c});
      apb(1'b0, P4MUX_PIN_OFS, 8'h00);
      p = ext;
      p[7] = ext[7] & ~(c[1] & i2c_data_out_low);
      chk(rd, {24'h0, p});
      chk(alt_in, {1'b1, c[1] ? p[7] : 1'b1, c[2] & p[6], c[4] ? p[2] : 1'b1,
        c[5] ? p[1] : 1'b1, c[6] ? p[0] : 1'b1, c[7] ? p[0] : 1'b1});
    end
    $display("alternate inputs done");
    expanded_bus_enable <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      r = $urandom;
      apb(1'b1, P4MUX_DIR_OFS, r);
      apb(1'b1, P4MUX_CTRL_OFS, {4'h0, i[1], 2'b00, i[0]});
      strobes <= $urandom;
      repeat (2) @(posedge pclk);
      chk(pin_oe_n, {i[0] | ~r[7], ~r[6], 3'b000, ~r[2:0]});
      chk(pin_out[5], i[1] ? strobes.io_strobe_n : strobes.address_strobe_n);
      chk(alt_in.wait_request_n, i[0] ? ext[7] : 1'b1);
    end
    $display("expanded mode done");
    expanded_bus_enable <= 1'b0;
    apb(1'b1, P4MUX_LATCH_OFS, 8'ha5);
    mode1 <= 1'b0;
    hw_standby <= 1'b1;
    repeat (2) @(posedge pclk);
    hw_standby <= 1'b0;
    repeat (2) @(posedge pclk);
    chk(pin_oe_n, 8'hff);
    apb(1'b1, P4MUX_DIR_OFS, 8'hbf);
    apb(1'b0, P4MUX_LATCH_OFS, 8'h00);
    chk(rd[7:0] & 8'hbf, 8'h00);
    $display("standby done");
    final_report;
  end
endmodule
bind p4mux_port p4mux_port_monitor p4mux_port_monitor_inst (.pclk, .presetn, .psel, .penable,
  .pwrite, .pready, .paddr, .prdata, .expanded_bus_enable, .hw_standby, .sys_clock_out,
  .strobes, .alt_in, .pin_in, .pin_out, .pin_oe_n);
